//--- rtl/adcfh_pkg.sv
// Purpose: shared constants for the adc fifo host port
// Assumes: 100 MHz sys_clk, control words arrive on a 16-bit bus
// Notes: field positions refer to the second control word
package adcfh_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_W = 16;
  localparam int SAMPLE_W = 12;
  localparam int MAX_CHANS = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W = 21;
  // control word layout
  localparam int REG_SEL_BIT = 10;
  localparam int THR_LO_BIT = 2;
  localparam int THR_HI_BIT = 3;
  localparam int FLAG_PULSE_BIT = 4;
  localparam int FLAG_POL_BIT = 5;
  localparam int RW_MODE_BIT = 6;
  localparam logic [15:0] CTRL0_RESET = 16'h0000;
  localparam logic [15:0] CTRL1_RESET = 16'h0030;
  // internal oscillator half period in single conversion mode
  localparam int OSC_HALF_NS = 50;
  localparam int OSC_HALF_CYC_RAW = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;
  localparam logic [4:0] THR_OFF = 5'h00;
  typedef enum logic [2:0] {
    ST_ARMED = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_DRAIN = 3'b100
  } adcfh_state_t;
endpackage : adcfh_pkg

//--- rtl/adcfh_fifo_if.sv
// Purpose: carrier between sequencer, read logic and result fifo
// Assumes: one clock, valid/ready on both sides
// Notes: level counts stored words
`timescale 1ns/1ps
interface adcfh_fifo_if #(parameter int W = 12, parameter int CW = 5);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [CW-1:0] level;
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data, level);
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, level);
endinterface : adcfh_fifo_if

//--- rtl/adcfh_fifo.sv
// Purpose: result fifo between conversion sequencer and host reads
// Assumes: synchronous reset, push and pop may coincide
// Notes: full refuses pushes, so the sequencer stalls
`timescale 1ns/1ps
module adcfh_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // fifo ports
  adcfh_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fifo depth must be a power of two");
    end
  end
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire do_push = f.push_valid && f.push_ready;
  wire do_pop = f.pop_valid && f.pop_ready;
  assign f.push_ready = (count_ff != (AW+1)'(DEPTH));
  assign f.pop_valid = (count_ff != '0);
  assign f.pop_data = mem_ff[rd_ptr_ff];
  assign f.level = count_ff;
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= f.push_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(do_push);
      rd_ptr_ff <= rd_ptr_ff + AW'(do_pop);
      count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  property p_no_overfill;
    @(posedge sys_clk) disable iff (!rstn) count_ff <= (AW+1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo count above depth");
endmodule : adcfh_fifo

//--- rtl/adcfh_host_port.sv
// Purpose: parallel host port of a multichannel adc with result fifo
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes: strobe edges are seen about two sys_clk cycles late
// Notes on behaviour
// - bits 2,3 of control word choose threshold
// - one/two channel threshold table per code
// - three/four channel table, four-channel 11 reserved
// - differential pair and single input count alike
// - results enter fifo in fixed channel order
// - read pulse pops word and drives bus
// - read pulse needs all selects, read, no write
// - write pulse latches bus into addressed register
// - write pulse needs all selects, write, no read
// - write input may become combined direction line
// - bit 4 level/pulse, bit 5 polarity
// - flag goes active when fill reaches threshold
// - flag returns inactive in both shaping modes
// - level flag clears on first read, rearms later
// - pulse lasts half sample or oscillator period
// - no new pulse before threshold reads done
// - bit 6 picks combined direction or split strobes
`timescale 1ns/1ps
module adcfh_host_port
  import adcfh_pkg::*;
#(
  parameter int DEPTH = adcfh_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host pins
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [adcfh_pkg::BUS_W-1:0] data_in,
  output logic [adcfh_pkg::BUS_W-1:0] data_out,
  output logic data_oe_n,
  output logic fifo_ready_flag,
  // conversion side
  input wire logic sample_clock_in,
  input wire logic continuous_mode,
  input wire logic [1:0] diff_pairs,
  input wire logic [2:0] single_inputs,
  input wire logic conv_valid,
  input wire logic [adcfh_pkg::MAX_CHANS*adcfh_pkg::SAMPLE_W-1:0] conv_data,
  output logic conv_ready,
  // control words
  output logic [adcfh_pkg::BUS_W-1:0] ctrl0_word,
  output logic [adcfh_pkg::BUS_W-1:0] ctrl1_word
);
  initial begin
    if (DEPTH < 14) begin
      $error("fifo depth must hold the largest threshold");
    end
  end
  localparam int CW = $clog2(DEPTH) + 1;

  // pin synchroniser; first stage feeds only the second
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  wire [SYNC_W-1:0] pins = {sample_clock_in, write_n, read_n, select_active_high,
                            select_active_low_n, data_in};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // idle pin levels, so no false strobe or sample clock edge follows reset
      sync1_ff <= 21'h0D_0000;
      sync2_ff <= 21'h0D_0000;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end
  wire [BUS_W-1:0] bus_s = sync2_ff[BUS_W-1:0];
  wire sel_low_n_s = sync2_ff[16];
  wire sel_high_s = sync2_ff[17];
  wire read_n_s = sync2_ff[18];
  wire write_n_s = sync2_ff[19];
  wire sclk_s = sync2_ff[20];

  // control registers
  logic [BUS_W-1:0] ctrl0_ff;
  logic [BUS_W-1:0] ctrl1_ff;
  wire [1:0] thr_code = {ctrl1_ff[THR_HI_BIT], ctrl1_ff[THR_LO_BIT]};
  wire pulse_mode = ctrl1_ff[FLAG_PULSE_BIT];
  wire active_high = ctrl1_ff[FLAG_POL_BIT];
  wire rw_mode = ctrl1_ff[RW_MODE_BIT];

  // internal strobes: last valid starts, first invalid ends
  wire both_sel = !sel_low_n_s && sel_high_s;
  // direction mode ignores read input; host keeps it high
  wire rd_req = rw_mode ? write_n_s : (!read_n_s && write_n_s);
  wire wr_req = rw_mode ? !write_n_s : (!write_n_s && read_n_s);
  wire internal_read_pulse = both_sel && rd_req;
  wire internal_write_pulse = both_sel && wr_req;
  logic rd_d_ff;
  logic wr_d_ff;
  logic sclk_d_ff;
  wire rd_start = internal_read_pulse && !rd_d_ff;
  wire wr_end = !internal_write_pulse && wr_d_ff;
  wire sclk_edge = sclk_s ^ sclk_d_ff;
  logic [BUS_W-1:0] wr_data_ff;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_d_ff <= 1'b0;
      wr_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      wr_data_ff <= 16'h0000;
    end else begin
      rd_d_ff <= internal_read_pulse;
      wr_d_ff <= internal_write_pulse;
      sclk_d_ff <= sclk_s;
      wr_data_ff <= internal_write_pulse ? bus_s : wr_data_ff;
    end
  end
  // latch on the closing edge so late data setup is still met
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl0_ff <= CTRL0_RESET;
      ctrl1_ff <= CTRL1_RESET;
    end else if (wr_end) begin
      ctrl0_ff <= wr_data_ff[REG_SEL_BIT] ? ctrl0_ff : wr_data_ff;
      ctrl1_ff <= wr_data_ff[REG_SEL_BIT] ? wr_data_ff : ctrl1_ff;
    end
  end
  assign ctrl0_word = ctrl0_ff;
  assign ctrl1_word = ctrl1_ff;

  // channel count: any input kind is one channel
  wire [3:0] chan_sum = 4'(diff_pairs) + 4'(single_inputs);
  wire [2:0] chans = (chan_sum == 4'h0) ? 3'd1 : (chan_sum > 4'h4) ? 3'd4 : chan_sum[2:0];

  // threshold table; reserved code never triggers
  function automatic logic [4:0] thr_lookup(input logic [2:0] n, input logic [1:0] c);
    logic [4:0] v;
    v = THR_OFF;
    unique case (n)
      3'd1: v = (c == 2'd0) ? 5'd1 : (c == 2'd1) ? 5'd4 : (c == 2'd2) ? 5'd8 : 5'd14;
      3'd2: v = (c == 2'd0) ? 5'd2 : (c == 2'd1) ? 5'd4 : (c == 2'd2) ? 5'd8 : 5'd12;
      3'd3: v = (c == 2'd0) ? 5'd3 : (c == 2'd1) ? 5'd6 : (c == 2'd2) ? 5'd9 : 5'd12;
      default: v = (c == 2'd0) ? 5'd4 : (c == 2'd1) ? 5'd8 : (c == 2'd2) ? 5'd12 : THR_OFF;
    endcase
    return v;
  endfunction : thr_lookup
  wire [4:0] thr_val = thr_lookup(chans, thr_code);

  // fifo and channel sequencer
  adcfh_fifo_if #(.W(SAMPLE_W), .CW(CW)) fq ();
  adcfh_fifo #(.W(SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .f(fq)
  );
  logic busy_ff;
  logic [1:0] seq_idx_ff;
  logic [2:0] frame_chans_ff;
  logic [MAX_CHANS*SAMPLE_W-1:0] frame_ff;
  wire last_chan = (3'(seq_idx_ff) + 3'd1) == frame_chans_ff;
  assign conv_ready = !busy_ff;
  assign fq.push_valid = busy_ff;
  assign fq.push_data = frame_ff[seq_idx_ff*SAMPLE_W +: SAMPLE_W];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      seq_idx_ff <= 2'd0;
      frame_chans_ff <= 3'd1;
      frame_ff <= '0;
    end else if (!busy_ff && conv_valid) begin
      busy_ff <= 1'b1;
      seq_idx_ff <= 2'd0;
      frame_chans_ff <= chans;
      frame_ff <= conv_data;
    end else if (busy_ff && fq.push_ready) begin
      busy_ff <= !last_chan;
      seq_idx_ff <= seq_idx_ff + 2'd1;
    end
  end

  // read path: pop on strobe start, drive bus while strobe lasts
  assign fq.pop_ready = rd_start;
  logic [BUS_W-1:0] data_out_ff;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      data_out_ff <= 16'h0000;
    end else if (rd_start) begin
      data_out_ff <= fq.pop_valid ? BUS_W'(fq.pop_data) : 16'h0000;
    end
  end
  assign data_out = data_out_ff;
  assign data_oe_n = !(internal_read_pulse && rd_d_ff);

  // ready flag; reads are counted in ST_ACTIVE and ST_DRAIN
  adcfh_state_t state_ff;
  adcfh_state_t nxt_state;
  logic [4:0] reads_left_ff;
  logic [4:0] nxt_reads_left;
  logic [7:0] pulse_cnt_ff;
  wire [4:0] reads_dec = (rd_start && reads_left_ff != 5'h00) ? reads_left_ff - 5'd1 :
                         reads_left_ff;
  wire trig = (thr_val != THR_OFF) && (fq.level >= CW'(thr_val));
  wire pulse_done = continuous_mode ? sclk_edge :
                    (pulse_cnt_ff == 8'(OSC_HALF_CYC - 1));
  always_comb begin
    nxt_state = state_ff;
    nxt_reads_left = reads_dec;
    unique case (state_ff)
      ST_ARMED: begin
        if (trig) begin
          nxt_state = ST_ACTIVE;
          nxt_reads_left = thr_val;
        end
      end
      ST_ACTIVE: begin
        if (pulse_mode ? pulse_done : rd_start) begin
          nxt_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (reads_dec == 5'h00) begin
          nxt_state = ST_ARMED;
        end
      end
      default: nxt_state = ST_ARMED;
    endcase
    if (nxt_state == ST_DRAIN && reads_dec == 5'h00 && state_ff != ST_ARMED) begin
      nxt_state = ST_ARMED;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= ST_ARMED;
      reads_left_ff <= 5'h00;
      pulse_cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      reads_left_ff <= nxt_reads_left;
      pulse_cnt_ff <= (state_ff == ST_ACTIVE) ? pulse_cnt_ff + 8'd1 : 8'h00;
    end
  end
  wire flag_on = (state_ff == ST_ACTIVE);
  logic flag_ff;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= active_high ? flag_on : !flag_on;
    end
  end
  assign fifo_ready_flag = flag_ff;

  property p_thr_one_chan;
    @(posedge sys_clk) disable iff (!rstn) (chans == 3'd1 && thr_code == 2'd3) |-> thr_val == 5'd14;
  endproperty
  a_thr_one_chan: assert property (p_thr_one_chan) else $error("one channel code 3 not 14");
  property p_thr_four_res;
    @(posedge sys_clk) disable iff (!rstn) (chans == 3'd4 && thr_code == 2'd3) |-> !trig;
  endproperty
  a_thr_four_res: assert property (p_thr_four_res) else $error("reserved code triggered");
  property p_read_data;
    @(posedge sys_clk) disable iff (!rstn) (rd_start && fq.pop_valid) |=> data_out == BUS_W'($past(fq.pop_data));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word not presented");
  property p_read_excl;
    @(posedge sys_clk) disable iff (!rstn) internal_read_pulse |-> !internal_write_pulse && both_sel;
  endproperty
  a_read_excl: assert property (p_read_excl) else $error("read pulse with write or no select");
  property p_write_ctrl1;
    @(posedge sys_clk) disable iff (!rstn) (wr_end && wr_data_ff[REG_SEL_BIT]) |=> ctrl1_ff == $past(wr_data_ff);
  endproperty
  a_write_ctrl1: assert property (p_write_ctrl1) else $error("control word not latched");
  property p_rw_read;
    @(posedge sys_clk) disable iff (!rstn) (rw_mode && internal_read_pulse) |-> write_n_s;
  endproperty
  a_rw_read: assert property (p_rw_read) else $error("direction mode read with line low");
  property p_trig_active;
    @(posedge sys_clk) disable iff (!rstn) (state_ff == ST_ARMED && trig) |=> state_ff == ST_ACTIVE ##1 flag_ff == active_high;
  endproperty
  a_trig_active: assert property (p_trig_active) else $error("threshold met but flag idle");
  property p_level_clear;
    @(posedge sys_clk) disable iff (!rstn) (flag_on && !pulse_mode && rd_start) |=> !flag_on;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("level flag kept after read");
  property p_pulse_len;
    @(posedge sys_clk) disable iff (!rstn) (flag_on && pulse_mode && !continuous_mode) |-> pulse_cnt_ff < 8'(OSC_HALF_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse longer than half period");
  property p_no_rearm;
    @(posedge sys_clk) disable iff (!rstn) (state_ff == ST_DRAIN && reads_dec != 5'h00) |=> !flag_on;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("flag rearmed before reads done");
endmodule : adcfh_host_port

//--- tb/adcfh_host_model.sv
// Purpose: host master model driving the parallel port pins
// Assumes: pins change at the falling edge of sys_clk
// Notes: released bus shows the inverse of the last word, never a stale copy
`timescale 1ns/1ps
module adcfh_host_model (
  // clock
  input wire logic sys_clk,
  // device answer
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  // host pins
  output logic select_active_low_n,
  output logic select_active_high,
  output logic read_n,
  output logic write_n,
  output logic [15:0] data_in
);
  logic dir_mode = 1'b0;
  initial begin
    select_active_low_n = 1'b1;
    select_active_high = 1'b0;
    read_n = 1'b1;
    write_n = 1'b1;
    data_in = 16'h0000;
  end
  // strobe or direction first, selects last, selects held five cycles
  task automatic xfer(input logic is_rd, input logic [15:0] wd, input logic clash,
                      output logic [15:0] rdata, output logic oe_n);
    @(negedge sys_clk);
    data_in = wd;
    if (dir_mode) begin
      write_n = is_rd;
      read_n = 1'b1;
    end else begin
      read_n = !(is_rd || clash);
      write_n = !(!is_rd || clash);
    end
    @(negedge sys_clk);
    select_active_low_n = 1'b0;
    select_active_high = 1'b1;
    repeat (5) @(negedge sys_clk);
    rdata = data_out;
    oe_n = data_oe_n;
    select_active_low_n = 1'b1;
    select_active_high = 1'b0;
    read_n = 1'b1;
    write_n = 1'b1;
    data_in = ~wd;
    repeat (5) @(negedge sys_clk);
  endtask : xfer
endmodule : adcfh_host_model

//--- tb/adcfh_host_port_tb_top.sv
// Purpose: self-checking bench for the adc fifo host port
// Assumes: queue model of fifo contents, threshold table in integers
// Notes: flag timing judged a few cycles after each frame settles
`timescale 1ns/1ps
module adcfh_host_port_tb_top;
  import adcfh_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sample_clock_in = 1'b0;
  logic continuous_mode = 1'b0;
  logic conv_valid = 1'b0;
  logic [1:0] diff_pairs = 2'h0;
  logic [2:0] single_inputs = 3'h1;
  logic [MAX_CHANS*SAMPLE_W-1:0] conv_data = '0;
  wire logic csl_n, csh, rd_n, wr_n, oe_n, flag, conv_ready;
  wire logic [BUS_W-1:0] din, dout, c0, c1;
  int fail_count = 0;
  int checks = 0;
  int q[$];
  int thr_tab[4][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}, '{3, 6, 9, 12}, '{4, 8, 12, 0}};
  int run = 0;
  int last_run = 0;
  int npulse = 0;
  int thr;
  logic [15:0] rv;
  logic ro;
  always #5 sys_clk = ~sys_clk;
  adcfh_host_port adcfh_host_port_i (.sys_clk(sys_clk), .rstn(rstn),
    .select_active_low_n(csl_n), .select_active_high(csh), .read_n(rd_n), .write_n(wr_n),
    .data_in(din), .data_out(dout), .data_oe_n(oe_n), .fifo_ready_flag(flag),
    .sample_clock_in(sample_clock_in), .continuous_mode(continuous_mode),
    .diff_pairs(diff_pairs), .single_inputs(single_inputs), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .ctrl0_word(c0), .ctrl1_word(c1));
  adcfh_host_model adcfh_host_model_i (.sys_clk(sys_clk), .data_out(dout), .data_oe_n(oe_n),
    .select_active_low_n(csl_n), .select_active_high(csh), .read_n(rd_n), .write_n(wr_n),
    .data_in(din));
  // active-low pulse widths, counted at falling edges
  always @(negedge sys_clk) begin
    if (rstn && flag === 1'b0) begin
      run = run + 1;
    end else begin
      if (run > 0) begin
        last_run = run;
        npulse = npulse + 1;
      end
      run = 0;
    end
  end
  task automatic test_done;
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  // one frame of n channels; the queue keeps channel order
  task automatic push(input int n);
    int i;
    i = 0;
    while (conv_ready !== 1'b1 && i < 100) begin
      @(negedge sys_clk);
      i++;
    end
    @(negedge sys_clk);
    conv_data = 48'({$urandom, $urandom});
    conv_valid = 1'b1;
    @(negedge sys_clk);
    conv_valid = 1'b0;
    for (i = 0; i < n; i++) q.push_back(int'(conv_data[i*SAMPLE_W +: SAMPLE_W]));
    i = 0;
    while (conv_ready !== 1'b1 && i < 100) begin
      @(negedge sys_clk);
      i++;
    end
    repeat (4) @(negedge sys_clk);
  endtask : push
  task automatic rd_chk;
    int v;
    adcfh_host_model_i.xfer(1'b1, 16'h0000, 1'b0, rv, ro);
    v = (q.size() > 0) ? q.pop_front() : 0;
    chk_bit(ro, 1'b0);
    chk_word(rv, 16'(v));
  endtask : rd_chk
  task automatic wr(input logic [15:0] w);
    adcfh_host_model_i.xfer(1'b0, w, 1'b0, rv, ro);
    chk_bit(ro, 1'b1);
  endtask : wr
  initial begin
    void'($urandom(37));
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    chk_word(c0, CTRL0_RESET);
    chk_word(c1, CTRL1_RESET);
    chk_bit(oe_n, 1'b1);
    chk_bit(flag, 1'b0);
    // both strobes low: neither transfer may happen
    adcfh_host_model_i.xfer(1'b0, 16'h0470, 1'b1, rv, ro);
    chk_bit(ro, 1'b1);
    chk_word(c1, CTRL1_RESET);
    wr(16'h0155);
    chk_word({6'h00, c0[9:0]}, 16'h0155);
    chk_word({6'h00, c1[9:0]}, CTRL1_RESET);
    for (int ch = 1; ch <= 4; ch++) begin
      for (int code = 0; code < 4; code++) begin
        @(negedge sys_clk);
        diff_pairs = 2'(ch / 2);
        single_inputs = 3'(ch - ch / 2);
        wr(16'h0420 | 16'(code << 2));
        chk_word({6'h00, c1[9:0]}, 16'h0020 | 16'(code << 2));
        thr = thr_tab[ch-1][code];
        do begin
          push(ch);
          chk_bit(flag, thr > 0 && q.size() >= thr);
        end while (thr > 0 && q.size() < thr);
        rd_chk();
        chk_bit(flag, 1'b0);
        while (q.size() > 0) rd_chk();
        chk_bit(flag, 1'b0);
      end
    end
    // pulse, active low, single conversion, one channel, threshold one
    diff_pairs = 2'h0;
    single_inputs = 3'h1;
    wr(16'h0410);
    last_run = 0;
    npulse = 0;
    push(1);
    repeat (10) @(negedge sys_clk);
    chk_word(16'(last_run), 16'(OSC_HALF_CYC));
    push(1);
    repeat (10) @(negedge sys_clk);
    chk_word(16'(npulse), 16'h0001);
    rd_chk();
    repeat (12) @(negedge sys_clk);
    chk_word(16'(npulse), 16'h0002);
    rd_chk();
    // continuous mode: pulse waits for a sample clock edge
    continuous_mode = 1'b1;
    push(1);
    repeat (30) @(negedge sys_clk);
    chk_bit(flag, 1'b0);
    sample_clock_in = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk_bit(flag, 1'b1);
    rd_chk();
    // combined direction line
    wr(16'h0460);
    adcfh_host_model_i.dir_mode = 1'b1;
    push(1);
    rd_chk();
    wr(16'h0470);
    chk_word({6'h00, c1[9:0]}, 16'h0070);
    test_done();
  end
  initial begin
    // a few thousand cycles expected; margin of several times that
    #200000;
    fail_count++;
    test_done();
  end
endmodule : adcfh_host_port_tb_top
